// ### rtl/aci_pkg.sv
// aci_pkg: widths, reset values and state codes shared by the injection
// result path and its holding register.
// assumes: a 10-bit converter core sits outside and reports one result per start.
package aci_pkg;
  // ==========================================================
  // widths
  localparam int RES_W = 10;          // converter result width
  localparam int CH_W  = 5;           // analog channel select width

  // ==========================================================
  // reset values
  localparam logic [RES_W-1:0] RES_RST  = 10'h000;
  localparam logic [CH_W-1:0]  CH_RST   = 5'h00;
  localparam logic             FLAG_RST = 1'b0;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [1:0] {
    ACI_IDLE = 2'b01,
    ACI_CONV = 2'b10
  } aci_state_t;
endpackage

// ### rtl/aci_hold_if.sv
// aci_hold_if: signals between the result path and its holding register.
// assumes: both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface aci_hold_if;
  logic                      load;      // capture a pending result
  logic                      load_inj;  // captured result belongs to the injection register
  logic [aci_pkg::RES_W-1:0] load_data;
  logic                      take;      // holder emptied this cycle
  logic                      full;
  logic                      is_inj;
  logic [aci_pkg::RES_W-1:0] data;

  modport ctrl (output load, output load_inj, output load_data, output take,
                input full, input is_inj, input data);
  modport hold (input load, input load_inj, input load_data, input take,
                output full, output is_inj, output data);
endinterface
`default_nettype wire

// ### rtl/aci_hold_reg.sv
// aci_hold_reg: one-entry temporary register of the wait-for-read scheme.
// assumes: controller never loads and takes in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module aci_hold_reg (
  input wire logic clk_sys,
  input wire logic rstn,
  aci_hold_if.hold hb
);
  logic                      full_reg,   full_next;
  logic                      inj_reg,    inj_next;
  logic [aci_pkg::RES_W-1:0] data_reg,   data_next;

  // ==========================================================
  // next state: load fills, take empties
  always_comb begin
    full_next = full_reg;
    inj_next  = inj_reg;
    data_next = data_reg;
    if (hb.take) begin
      full_next = 1'b0;
    end
    if (hb.load) begin
      full_next = 1'b1;
      inj_next  = hb.load_inj;
      data_next = hb.load_data;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      full_reg <= aci_pkg::FLAG_RST;
      inj_reg  <= aci_pkg::FLAG_RST;
      data_reg <= aci_pkg::RES_RST;
    end else begin
      full_reg <= full_next;
      inj_reg  <= inj_next;
      data_reg <= data_next;
    end
  end

  assign hb.full   = full_reg;
  assign hb.is_inj = inj_reg;
  assign hb.data   = data_reg;
endmodule // aci_hold_reg
`default_nettype wire

// ### rtl/aci_result_path.sv
// aci_result_path: sequencing of standard and injected conversions and the
// result registers with their wait-for-read holding register.
// assumes: the converter core answers each conv_start with one conv_done;
// reads and triggers are one-cycle pulses from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module aci_result_path (
  input  wire logic                      clk_sys,
  input  wire logic                      rstn,
  // configuration
  input  wire logic                      wait_read_mode,   // wait-for-result-read enable
  input  wire logic                      continuous_mode,
  input  wire logic                      scan_mode,
  input  wire logic [aci_pkg::CH_W-1:0]  std_channel,      // channel, or last channel in scan
  input  wire logic                      defect_compat,    // 1: behave as the flawed silicon
  input  wire logic                      std_start,        // pulse: begin standard conversions
  input  wire logic                      std_stop,         // pulse: end standard conversions
  // injection trigger from the capture_compare_unit capture_compare_unit_trigger_channel
  input  wire logic                      inj_request,
  input  wire logic [aci_pkg::CH_W-1:0]  inj_channel,
  // reader side (processor or event_transfer_channel)
  input  wire logic                      std_result_read,
  input  wire logic                      inj_result_read,
  input  wire logic                      inj_flag_clear,
  output logic [aci_pkg::RES_W-1:0]      standard_result_register,
  output logic [aci_pkg::RES_W-1:0]      injection_result_register,
  output logic                           std_result_valid,
  output logic                           inj_result_valid,
  output logic                           injection_done_flag,
  output logic                           injection_done_interrupt,
  output logic                           hold_full,
  output logic                           stalled,
  output logic                           busy,
  // converter core
  output logic                           conv_start,
  output logic [aci_pkg::CH_W-1:0]       conv_channel,
  output logic                           conv_is_inj,
  input  wire logic                      conv_done,
  input  wire logic [aci_pkg::RES_W-1:0] conv_data
);
  aci_hold_if hb ();

  aci_hold_reg u_hold (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .hb      (hb)
  );

  aci_pkg::aci_state_t             st_reg,       st_next;
  logic                            run_reg,      run_next;
  logic [aci_pkg::CH_W-1:0]        scan_reg,     scan_next;
  logic                            pend_reg,     pend_next;
  logic [aci_pkg::CH_W-1:0]        pch_reg,      pch_next;
  logic                            cinj_reg,     cinj_next;
  logic [aci_pkg::CH_W-1:0]        cch_reg,      cch_next;
  logic                            start_reg,    start_next;
  logic [aci_pkg::RES_W-1:0]       sres_reg,     sres_next;
  logic [aci_pkg::RES_W-1:0]       ires_reg,     ires_next;
  logic                            sful_reg,     sful_next;
  logic                            iful_reg,     iful_next;
  logic                            flag_reg,     flag_next;
  logic                            irq_reg,      irq_next;
  logic                            wait_d_reg;
  logic                            mode_drop;

  // leaving wait mode releases whatever the holder keeps
  assign mode_drop = wait_d_reg & ~wait_read_mode;

  // ==========================================================
  // next-state logic of sequencer and result registers
  always_comb begin
    st_next      = st_reg;
    run_next     = run_reg;
    scan_next    = scan_reg;
    pend_next    = pend_reg;
    pch_next     = pch_reg;
    cinj_next    = cinj_reg;
    cch_next     = cch_reg;
    start_next   = 1'b0;
    sres_next    = sres_reg;
    ires_next    = ires_reg;
    sful_next    = sful_reg;
    iful_next    = iful_reg;
    flag_next    = flag_reg;
    irq_next     = 1'b0;
    hb.load      = 1'b0;
    hb.load_inj  = 1'b0;
    hb.load_data = conv_data;
    hb.take      = 1'b0;

    // software clear of the done flag; a set below overrides it
    if (inj_flag_clear) begin
      flag_next = 1'b0;
    end

    // standard sequence control
    if (std_start) begin
      run_next  = 1'b1;
      scan_next = aci_pkg::CH_RST;
    end else if (std_stop) begin
      run_next = 1'b0;
    end

    // injection trigger is latched; a new one overwrites the channel
    if (inj_request) begin
      pend_next = 1'b1;
      pch_next  = inj_channel;
    end

    // reads free the registers; held data then moves up
    if (std_result_read) begin
      sful_next = 1'b0;
      if (hb.full && !hb.is_inj) begin
        sres_next = hb.data;
        sful_next = 1'b1;
        hb.take   = 1'b1;
      end
    end
    if (inj_result_read) begin
      iful_next = 1'b0;
      if (hb.full && hb.is_inj) begin
        ires_next = hb.data;
        iful_next = 1'b1;
        hb.take   = 1'b1;
        if (!defect_compat) begin
          flag_next = 1'b1;
          irq_next  = 1'b1;
        end                                                          // else silent
      end
    end

    // wait mode dropped: holder empties into its target, nothing waits
    if (mode_drop) begin
      sful_next = 1'b0;
      iful_next = 1'b0;
      if (hb.full && !hb.take) begin
        hb.take = 1'b1;
        if (hb.is_inj) begin
          ires_next = hb.data;
          flag_next = 1'b1;
          irq_next  = 1'b1;
        end else begin
          sres_next = hb.data;
        end
      end
    end

    case (st_reg)
      aci_pkg::ACI_IDLE: begin
        // holder occupied: both kinds of conversion are suspended
        if (!hb.full) begin
          if (pend_reg) begin
            st_next    = aci_pkg::ACI_CONV;
            cinj_next  = 1'b1;
            cch_next   = pch_reg;
            start_next = 1'b1;
            pend_next  = inj_request;                               // new trigger not lost
          end else if (run_reg && !std_stop) begin
            st_next    = aci_pkg::ACI_CONV;
            cinj_next  = 1'b0;
            cch_next   = scan_mode ? scan_reg : std_channel;
            start_next = 1'b1;
          end
        end
      end
      aci_pkg::ACI_CONV: begin
        if (conv_done) begin
          st_next = aci_pkg::ACI_IDLE;
          if (cinj_reg) begin
            // unread earlier injection result: park the new one
            if (wait_read_mode && iful_next) begin
              hb.load     = 1'b1;
              hb.load_inj = 1'b1;
            end else begin
              ires_next = conv_data;
              iful_next = wait_read_mode;
              flag_next = 1'b1;
              irq_next  = 1'b1;
            end
          end else begin
            if (wait_read_mode && sful_next) begin
              hb.load = 1'b1;
            end else begin
              sres_next = conv_data;
              sful_next = 1'b1;
            end
            // injection never alters the standard sequence position
            if (scan_mode) begin
              if (scan_reg == std_channel) begin
                scan_next = aci_pkg::CH_RST;
                run_next  = run_next & continuous_mode;
              end else begin
                scan_next = scan_reg + 1'b1;
              end
            end else if (!continuous_mode) begin
              run_next = 1'b0;
            end
          end
        end
      end
      default: begin
        st_next = aci_pkg::ACI_IDLE;
      end
    endcase
  end

  // ==========================================================
  // registers; reset leaves the converter idle with nothing pending
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      st_reg     <= aci_pkg::ACI_IDLE;
      run_reg    <= aci_pkg::FLAG_RST;
      scan_reg   <= aci_pkg::CH_RST;
      pend_reg   <= aci_pkg::FLAG_RST;
      pch_reg    <= aci_pkg::CH_RST;
      cinj_reg   <= aci_pkg::FLAG_RST;
      cch_reg    <= aci_pkg::CH_RST;
      start_reg  <= aci_pkg::FLAG_RST;
      sres_reg   <= aci_pkg::RES_RST;
      ires_reg   <= aci_pkg::RES_RST;
      sful_reg   <= aci_pkg::FLAG_RST;
      iful_reg   <= aci_pkg::FLAG_RST;
      flag_reg   <= aci_pkg::FLAG_RST;
      irq_reg    <= aci_pkg::FLAG_RST;
      wait_d_reg <= aci_pkg::FLAG_RST;
    end else begin
      st_reg     <= st_next;
      run_reg    <= run_next;
      scan_reg   <= scan_next;
      pend_reg   <= pend_next;
      pch_reg    <= pch_next;
      cinj_reg   <= cinj_next;
      cch_reg    <= cch_next;
      start_reg  <= start_next;
      sres_reg   <= sres_next;
      ires_reg   <= ires_next;
      sful_reg   <= sful_next;
      iful_reg   <= iful_next;
      flag_reg   <= flag_next;
      irq_reg    <= irq_next;
      wait_d_reg <= wait_read_mode;
    end
  end

  // ==========================================================
  // outputs
  assign standard_result_register  = sres_reg;
  assign injection_result_register = ires_reg;
  assign std_result_valid          = sful_reg;
  assign inj_result_valid          = iful_reg;
  assign injection_done_flag       = flag_reg;
  assign injection_done_interrupt  = irq_reg;
  assign hold_full                 = hb.full;
  // waiting on a read with work queued: the visible form of the lock-up
  assign stalled     = hb.full & (st_reg == aci_pkg::ACI_IDLE) & (pend_reg | run_reg);
  assign busy        = (st_reg == aci_pkg::ACI_CONV);
  assign conv_start  = start_reg;
  assign conv_channel = cch_reg;
  assign conv_is_inj = cinj_reg;
endmodule // aci_result_path
`default_nettype wire

// ### sim/aci_conv_model.sv
// aci_conv_model: converter core answering each start after a chosen delay
// assumes: starts arrive only while the core is idle
`timescale 1ns/1ps
`default_nettype none
module aci_conv_model (
  input  wire logic                     clk_sys,
  input  wire logic                     rstn,
  input  wire logic                     conv_start,
  input  wire logic [aci_pkg::CH_W-1:0] conv_channel,
  input  wire logic                     conv_is_inj,
  input  wire logic [3:0]               lat,
  output logic                          conv_done,
  output logic [aci_pkg::RES_W-1:0]     conv_data
);
  logic       run_reg;
  logic [3:0] cnt_reg;
  // ==========================================
  // conversion timer; data toggles while not valid so stale words never pass
  always_ff @(posedge clk_sys) begin
    conv_done <= 1'b0;
    conv_data <= ~conv_data;
    if (!rstn) begin
      run_reg   <= 1'b0;
      conv_data <= 10'h155;
    end else if (conv_start) begin
      run_reg <= 1'b1;
      cnt_reg <= lat;
    end else if (run_reg && cnt_reg == 4'h0) begin
      run_reg   <= 1'b0;
      conv_done <= 1'b1;
      conv_data <= {conv_is_inj, 4'ha, conv_channel}; // word names kind and channel
    end else if (run_reg) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule // aci_conv_model
`default_nettype wire

// ### sim/aci_result_path_props.sv
// aci_result_path_props: port-level assertions on the injection result path
// assumes: bound to aci_result_path, one clock domain
`timescale 1ns/1ps
`default_nettype none
module aci_result_path_props (
  input wire logic                      clk_sys,
  input wire logic                      rstn,
  input wire logic                      wait_read_mode,
  input wire logic                      defect_compat,
  input wire logic                      std_result_read,
  input wire logic                      inj_result_read,
  input wire logic [aci_pkg::RES_W-1:0] injection_result_register,
  input wire logic                      std_result_valid,
  input wire logic                      inj_result_valid,
  input wire logic                      injection_done_flag,
  input wire logic                      injection_done_interrupt,
  input wire logic                      hold_full,
  input wire logic                      busy,
  input wire logic                      conv_start,
  input wire logic                      conv_is_inj,
  input wire logic                      conv_done,
  input wire logic [aci_pkg::RES_W-1:0] conv_data
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // ==========================================
  // kind of the held word, caught when the holder fills
  logic held_inj_reg;
  wire  inj_done = busy && conv_done && conv_is_inj;
  always_ff @(posedge clk_sys) begin
    if (!rstn) held_inj_reg <= 1'b0;
    else if ($rose(hold_full)) held_inj_reg <= conv_is_inj;
  end
  // ==========================================
  // properties
  a_inj_posted: assert property (inj_done && !inj_result_valid && !hold_full |=>
    injection_result_register == $past(conv_data) && injection_done_interrupt)
    else $error("injection result not posted");
  a_irq_pulse: assert property (injection_done_interrupt |->
    injection_done_flag ##1 !injection_done_interrupt) else $error("interrupt not a pulse");
  a_inj_held: assert property (inj_done && inj_result_valid && wait_read_mode
    && !inj_result_read |=> hold_full && $stable(injection_result_register))
    else $error("second injection result not held");
  a_std_held: assert property (busy && conv_done && !conv_is_inj && std_result_valid
    && wait_read_mode && !std_result_read |=> hold_full) else $error("standard not held");
  a_no_start_full: assert property (hold_full |=> !conv_start)
    else $error("conversion started with holder full");
  a_start_pulse: assert property (conv_start |-> busy ##1 !conv_start)
    else $error("start not a single pulse");
  a_read_moves: assert property (hold_full && held_inj_reg && inj_result_read
    && wait_read_mode |=> !hold_full && injection_done_interrupt != $past(defect_compat))
    else $error("held injection word not moved as set");
  a_mode_release: assert property ($fell(wait_read_mode) && hold_full |->
    ##[1:3] !hold_full) else $error("mode drop did not release holder");
  a_reset_idle: assert property (disable iff (1'b0) !rstn |=> !hold_full
    && !injection_done_flag && !busy && !conv_start) else $error("reset left state");
endmodule // aci_result_path_props
bind aci_result_path aci_result_path_props u_props (.clk_sys, .rstn, .wait_read_mode,
  .defect_compat, .std_result_read, .inj_result_read, .injection_result_register,
  .std_result_valid, .inj_result_valid, .injection_done_flag, .injection_done_interrupt,
  .hold_full, .busy, .conv_start, .conv_is_inj, .conv_done, .conv_data);
`default_nettype wire

// ### sim/aci_result_path_tb_top.sv
// aci_result_path_tb_top: directed and random traffic through the result path
// assumes: aci_conv_model stands in for the converter core
`timescale 1ns/1ps
`default_nettype none
module aci_result_path_tb_top;
  logic clk_sys = 1'b0, rstn = 1'b0, wait_read_mode = 1'b0, continuous_mode = 1'b0;
  logic scan_mode = 1'b0, defect_compat = 1'b0, std_start = 1'b0, std_stop = 1'b0;
  logic inj_request = 1'b0, std_result_read = 1'b0, inj_result_read = 1'b0;
  logic inj_flag_clear = 1'b0, std_result_valid, inj_result_valid, injection_done_flag;
  logic injection_done_interrupt, hold_full, stalled, busy, conv_start, conv_is_inj;
  logic conv_done, ir, ird;
  logic [4:0]  std_channel = 5'h03, inj_channel = 5'h00, conv_channel, sc;
  logic [9:0]  standard_result_register, injection_result_register, conv_data;
  logic [3:0]  lat = 4'h2;
  logic [31:0] rs = 32'h5255, r;
  logic [4:0]  q[$];
  int          n_fail = 0, check_count = 0, k;
  aci_result_path uut (.clk_sys, .rstn, .wait_read_mode, .continuous_mode, .scan_mode,
    .std_channel, .defect_compat, .std_start, .std_stop, .inj_request, .inj_channel,
    .std_result_read, .inj_result_read, .inj_flag_clear, .standard_result_register,
    .injection_result_register, .std_result_valid, .inj_result_valid, .injection_done_flag,
    .injection_done_interrupt, .hold_full, .stalled, .busy, .conv_start, .conv_channel,
    .conv_is_inj, .conv_done, .conv_data);
  aci_conv_model u_core (.clk_sys, .rstn, .conv_start, .conv_channel, .conv_is_inj, .lat,
    .conv_done, .conv_data);
  always #20 clk_sys = ~clk_sys;
  // ==========================================
  // helpers
  function automatic logic [9:0] ex(input logic i, input logic [4:0] c);
    return {i, 4'ha, c};
  endfunction
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
  endtask
  task automatic inj(input logic [4:0] c);
    @(negedge clk_sys) inj_channel = c;
    inj_request = 1'b1;
    @(negedge clk_sys) inj_request = 1'b0;
  endtask
  // back-to-back double read keeps the flawed path from stalling
  task automatic rd2();
    @(negedge clk_sys) inj_result_read = 1'b1;
    cyc(2);
    inj_result_read = 1'b0;
  endtask
  // bounded wait: 0 interrupt, 1 holder full, 2 stalled, 3 idle
  task automatic wt(input int w);
    for (int i = 0; i < 300; i++) begin
      if ((w == 0 && injection_done_interrupt) || (w == 1 && hold_full)
          || (w == 2 && stalled) || (w == 3 && !busy)) return;
      @(negedge clk_sys);
    end
    n_fail++;
    give_verdict();
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    cyc(5);
    check("hold", hold_full, 0);
    check("flag", injection_done_flag, 0);
    check("busy", busy, 0);
    rstn = 1'b1;
  endtask
  // ==========================================
  // main sequence
  initial begin
    do_reset();
    wait_read_mode = 1'b1;
    inj(5'h05); wt(0); check("ires", injection_result_register, ex(1, 5'h05));
    check("flag", injection_done_flag, 1);
    pulse(inj_flag_clear);
    inj(5'h06); wt(1); check("ires", injection_result_register, ex(1, 5'h05));
    pulse(inj_result_read); check("irq", injection_done_interrupt, 1);
    check("ires", injection_result_register, ex(1, 5'h06));
    rd2(); check("ivalid", inj_result_valid, 0);
    defect_compat = 1'b1;
    inj(5'h07); wt(0); inj(5'h08); wt(1);
    pulse(inj_result_read); check("irq", injection_done_interrupt, 0);
    check("ires", injection_result_register, ex(1, 5'h08));
    // stall only shows with work queued behind the silently refilled holder
    inj(5'h09); wt(1); inj(5'h0a); wt(2); cyc(20); check("stall", stalled, 1);
    @(negedge clk_sys) wait_read_mode = 1'b0;
    @(negedge clk_sys) wait_read_mode = 1'b1;
    cyc(3); check("hold", hold_full, 0);
    check("ires", injection_result_register, ex(1, 5'h09));
    // the queued injection runs once the holder is released
    wt(0); check("ires", injection_result_register, ex(1, 5'h0a));
    rd2(); inj(5'h0b); wt(0); rd2(); inj(5'h0c); wt(0);
    check("ires", injection_result_register, ex(1, 5'h0c));
    defect_compat = 1'b0;
    rd2(); pulse(std_start); cyc(20); pulse(std_start); wt(1);
    inj(5'h04); cyc(20); check("busy", busy, 0);
    pulse(std_result_read); check("sres", standard_result_register, ex(0, 5'h03));
    wt(0); check("ires", injection_result_register, ex(1, 5'h04));
    rd2();
    // random injections over continuous and scanning standard runs
    for (k = 0; k < 2; k++) begin
      scan_mode = k[0];
      continuous_mode = 1'b1;
      sc = 5'h00;
      pulse(std_start);
      repeat (400) begin
        @(negedge clk_sys) r = rnd();
        lat = r[3:0];
        ir = 1'b0;
        ird = 1'b0;
        std_result_read = std_result_valid && r[4];
        if (std_result_read) begin
          check("sres", standard_result_register, ex(0, scan_mode ? sc : 5'h03));
          sc = (sc == 5'h03) ? 5'h00 : sc + 5'h01;
        end
        if (injection_done_interrupt) begin
          check("ires", injection_result_register, ex(1, q.pop_front()));
          ird = 1'b1;
        end else if (!inj_result_valid && q.size() == 0 && r[7:5] == 3'h0) begin
          ir = 1'b1;
          inj_channel = r[12:8];
          q.push_back(r[12:8]);
        end
        inj_request = ir;
        inj_result_read = ird;
      end
      @(negedge clk_sys) inj_request = 1'b0;
      inj_result_read = 1'b0;
      std_result_read = 1'b0;
      // standard reads first: a queued injection may wait behind a held standard word
      pulse(std_stop); cyc(40); wt(3);
      pulse(std_result_read); pulse(std_result_read);
      check("svalid", std_result_valid, 0);
      cyc(40); wt(3); rd2();
      q.delete();
    end
    do_reset();
    give_verdict();
  end
endmodule // aci_result_path_tb_top
`default_nettype wire
